// ---- include/tgt_pkg.sv ----
// constants shared by the trip target logic
package tgt_pkg;
  localparam int NUM_LEDS       = 8;
  localparam int NUM_TGT        = 7;
  localparam int MAG_W          = 16;
  localparam int NUM_DIFF       = 2;
  localparam int NUM_IOC        = 6;
  localparam int NUM_TOC        = 5;
  localparam int NUM_RES        = 2;
  localparam int NUM_POC        = 4;
  localparam int NUM_SEQ        = 4;
  // target bit positions
  localparam int TGT_DIFF       = 0;
  localparam int TGT_IOC        = 1;
  localparam int TGT_TOC        = 2;
  localparam int TGT_PHA        = 3;
  localparam int TGT_PHB        = 4;
  localparam int TGT_PHC        = 5;
  localparam int TGT_RES        = 6;
  // led order: in-service first, then the seven targets
  localparam int LED_EN         = 0;
  localparam logic [6:0] TGT_RESET = 7'h00;
endpackage

// ---- rtl/phase_select.sv ----
// phase selection for the target logic
`timescale 1ns/1ns
`default_nettype none
module phase_select
  import tgt_pkg::*;
(
  // element status
  input  wire logic [2:0]               diff_phase,
  input  wire logic [NUM_POC-1:0]       poc_trip,
  input  wire logic [NUM_SEQ-1:0]       seq_trip,
  // magnitudes and pickups
  input  wire logic [3*MAG_W-1:0]       phase_mag,
  input  wire logic [NUM_POC*MAG_W-1:0] poc_pickup,
  // result
  output logic [2:0]                    phase_sel
);
  logic [2:0] largest;
  logic [2:0] over;

  // one-hot largest phase, lowest index wins ties
  always_comb begin
    logic [MAG_W-1:0] a;
    logic [MAG_W-1:0] b;
    logic [MAG_W-1:0] c;
    a = phase_mag[0 +: MAG_W];
    b = phase_mag[MAG_W +: MAG_W];
    c = phase_mag[2*MAG_W +: MAG_W];
    if (a >= b && a >= c) begin
      largest = 3'h1;
    end else if (b >= c) begin
      largest = 3'h2;
    end else begin
      largest = 3'h4;
    end
  end

  // phase current above pickup of any tripped phase element
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_ph
      always_comb begin
        over[p] = 1'b0;
        for (int e = 0; e < NUM_POC; e++) begin
          if (poc_trip[e] && phase_mag[p*MAG_W +: MAG_W] > poc_pickup[e*MAG_W +: MAG_W]) begin
            over[p] = 1'b1; // [R9]
          end
        end
      end
    end
  endgenerate

  // differential involvement, overcurrent, and largest phase
  assign phase_sel = diff_phase                     // [R8]
                   | over                           // [R9]
                   | ((|seq_trip) ? largest : 3'h0); // [R10]
endmodule // phase_select
`default_nettype wire

// ---- rtl/trip_targets.sv ----
// front-panel trip target capture, hold, clear and retention
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - eight leds; in-service lit unless targets reassigned or self-test failed
// R2 - sample at trip rising edge and one cycle later, OR both
// R3 - differential target when any differential element picked up
// R4 - instantaneous target for any instantaneous or definite-time element pickup
// R5 - inverse-time target when any inverse-time element timed out
// R6 - each phase target lit when phase selection picks it
// R7 - residual target when any residual element tripped
// R8 - phase selected when differential operation reports that phase
// R9 - phase selected when phase element tripped and current exceeds its pickup
// R10 - residual or negative-sequence trip selects only the largest phase
// R11 - store targets whenever they change; reload after power returns
// R12 - button or serial clear empties targets, but not while trip persists
// R13 - edge from registered trip; second capture armed for next cycle
module trip_targets
  import tgt_pkg::*;
(
  // clock and reset
  input  wire logic                       MCLK,
  input  wire logic                       NRST,
  // trip and element status
  input  wire logic                       TRIP,
  input  wire logic [NUM_DIFF-1:0]        DIFF_PICKUP,
  input  wire logic [2:0]                 DIFF_PHASE,
  input  wire logic [NUM_IOC-1:0]         IOC_PICKUP,
  input  wire logic [NUM_TOC-1:0]         TOC_TIMEOUT,
  input  wire logic [NUM_RES-1:0]         RES_TRIP,
  input  wire logic [NUM_POC-1:0]         POC_TRIP,
  input  wire logic [NUM_SEQ-1:0]         SEQ_TRIP,
  // magnitudes and pickups
  input  wire logic [3*MAG_W-1:0]         PHASE_MAG,
  input  wire logic [NUM_POC*MAG_W-1:0]   POC_PICKUP,
  // operator controls, from pins
  input  wire logic                       CLEAR_BUTTON,
  input  wire logic                       CLEAR_SERIAL,
  input  wire logic                       TGT_REASSIGNED,
  input  wire logic                       SELFTEST_FAIL,
  // nonvolatile storage
  input  wire logic                       NV_VALID,
  input  wire logic [NUM_TGT-1:0]         NV_RDATA,
  output logic                            NV_WRITE,
  output logic [NUM_TGT-1:0]              NV_WDATA,
  // indicators
  output logic [NUM_LEDS-1:0]             LEDS
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers for pin-level controls

  logic [1:0] btn_s_q;
  logic [1:0] ser_s_q;
  logic [1:0] rea_s_q;
  logic [1:0] stf_s_q;
  logic       btn_sync;
  logic       ser_sync;
  logic       rea_sync;
  logic       stf_sync;

  // front-panel clear button, two flops
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      btn_s_q <= 2'h0;
    end else begin
      btn_s_q <= {btn_s_q[0], CLEAR_BUTTON};
    end
  end

  // serial clear command, two flops
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ser_s_q <= 2'h0;
    end else begin
      ser_s_q <= {ser_s_q[0], CLEAR_SERIAL};
    end
  end

  // target reassignment level, two flops
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rea_s_q <= 2'h0;
    end else begin
      rea_s_q <= {rea_s_q[0], TGT_REASSIGNED};
    end
  end

  // self-test failure level, two flops
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      stf_s_q <= 2'h0;
    end else begin
      stf_s_q <= {stf_s_q[0], SELFTEST_FAIL};
    end
  end

  // only the second flop of each pair feeds logic
  assign btn_sync = btn_s_q[1];
  assign ser_sync = ser_s_q[1];
  assign rea_sync = rea_s_q[1];
  assign stf_sync = stf_s_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // element class summaries

  logic               diff_any;
  logic               inst_any;
  logic               inv_any;
  logic               res_any;
  logic [NUM_SEQ-1:0] unbal_trip;

  // any element of each class
  assign diff_any = |DIFF_PICKUP; // [R3]
  assign inst_any = |IOC_PICKUP;  // [R4]
  assign inv_any  = |TOC_TIMEOUT; // [R5]
  assign res_any  = |RES_TRIP;    // [R7]

  // residual trips join the negative-sequence ones, padded to the wider vector
  assign unbal_trip = SEQ_TRIP | {{(NUM_SEQ-NUM_RES){1'b0}}, RES_TRIP}; // [R10]

  //////////////////////////////////////////////////////////////////////////////
  // fault indication vector

  logic [2:0]         phase_sel;
  logic [NUM_TGT-1:0] fault_now;

  // phase choice from differential, overcurrent and largest current
  phase_select u_phase_select (
    .diff_phase (DIFF_PHASE),
    .poc_trip   (POC_TRIP),
    .seq_trip   (unbal_trip),
    .phase_mag  (PHASE_MAG),
    .poc_pickup (POC_PICKUP),
    .phase_sel  (phase_sel)
  );

  // one bit per front-panel target
  always_comb begin
    fault_now           = '0;
    fault_now[TGT_DIFF] = diff_any;       // [R3]
    fault_now[TGT_IOC]  = inst_any;       // [R4]
    fault_now[TGT_TOC]  = inv_any;        // [R5]
    fault_now[TGT_PHA]  = phase_sel[0];   // [R6]
    fault_now[TGT_PHB]  = phase_sel[1];   // [R6]
    fault_now[TGT_PHC]  = phase_sel[2];   // [R6]
    fault_now[TGT_RES]  = res_any;        // [R7]
  end

  //////////////////////////////////////////////////////////////////////////////
  // trip edge and second-sample arming

  // capture states: waiting for an edge, or taking the second sample
  typedef enum logic {
    CAP_IDLE   = 1'b0,
    CAP_SECOND = 1'b1
  } cap_state_e;

  logic       trip_q;
  logic       trip_rise;
  logic       cap_second;
  cap_state_e cap_q;
  cap_state_e cap_d;

  // edge against last cycle's trip level
  assign trip_rise = TRIP & ~trip_q; // [R13]

  // trip level one cycle back
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= TRIP; // [R13]
    end
  end

  // second capture is armed only for the cycle after an edge
  always_comb begin
    cap_d = CAP_IDLE;
    case (cap_q)
      CAP_IDLE: begin
        if (trip_rise) begin
          cap_d = CAP_SECOND; // [R13]
        end
      end
      CAP_SECOND: begin
        cap_d = CAP_IDLE; // a held trip takes no third sample
      end
      default: begin
        cap_d = CAP_IDLE;
      end
    endcase
  end

  // capture state register
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cap_q <= CAP_IDLE;
    end else begin
      cap_q <= cap_d;
    end
  end

  // second sample strobe
  assign cap_second = (cap_q == CAP_SECOND); // [R13]

  //////////////////////////////////////////////////////////////////////////////
  // target register with restore and clear

  logic [NUM_TGT-1:0] tgt_q;
  logic [NUM_TGT-1:0] tgt_d;
  logic               restored_q;
  logic               restore;
  logic               clear_req;
  logic               clear_ok;
  logic               capture;

  // reload once per reset; clear only once the trip has gone
  assign restore   = !restored_q && NV_VALID;  // [R11]
  assign clear_req = btn_sync | ser_sync;      // [R12]
  assign clear_ok  = clear_req && !TRIP;       // [R12]
  assign capture   = trip_rise | cap_second;   // [R2]

  // per target: reload or clear, then OR in a capture, so capture beats clear
  genvar t;
  generate
    for (t = 0; t < NUM_TGT; t++) begin : g_tgt
      always_comb begin
        tgt_d[t] = tgt_q[t];
        if (restore) begin
          tgt_d[t] = NV_RDATA[t]; // [R11]
        end else if (clear_ok) begin
          tgt_d[t] = TGT_RESET[t]; // [R12]
        end
        if (capture && fault_now[t]) begin
          tgt_d[t] = 1'b1; // [R2]
        end
      end
    end
  endgenerate

  // held targets
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      tgt_q <= TGT_RESET;
    end else begin
      tgt_q <= tgt_d;
    end
  end

  // restore done; changes before it are not written back
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      restored_q <= 1'b0;
    end else if (NV_VALID) begin
      restored_q <= 1'b1; // [R11]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // nonvolatile write on change

  logic tgt_change;

  // any target differs from the held value, once restored
  assign tgt_change = restored_q && (tgt_d != tgt_q); // [R11]

  // one-cycle write strobe per change
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      NV_WRITE <= 1'b0;
    end else begin
      NV_WRITE <= tgt_change; // [R11]
    end
  end

  // value to store, launched with the strobe
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      NV_WDATA <= TGT_RESET;
    end else begin
      NV_WDATA <= tgt_d; // [R11]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indicator drive

  logic in_service;

  // in-service lamp dark while reassigned or while a self-test failure is flagged
  assign in_service = ~(rea_sync | stf_sync); // [R1]

  // in-service lamp then the seven targets
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      LEDS <= '0;
    end else begin
      LEDS[LED_EN]              <= in_service; // [R1]
      LEDS[NUM_LEDS-1:LED_EN+1] <= tgt_d;      // [R1]
    end
  end

endmodule // trip_targets
`default_nettype wire

// ---- verification/nv_store_model.sv ----
// nonvolatile target store model
`timescale 1ns/1ns
`default_nettype none
module nv_store_model
  import tgt_pkg::*;
(
  // clock and write side
  input  wire logic               clk,
  input  wire logic               nv_write,
  input  wire logic [NUM_TGT-1:0] nv_wdata,
  // read side
  output logic                    nv_valid,
  output logic [NUM_TGT-1:0]      nv_rdata
);
  // store keeps its content across device resets
  assign nv_valid = 1'b1;
  // one process owns the stored word: empty at power-up, then written per strobe
  initial begin
    nv_rdata = '0;
    forever begin
      @(posedge clk);
      if (nv_write) nv_rdata <= nv_wdata;
    end
  end
endmodule // nv_store_model
`default_nettype wire

// ---- verification/trip_targets_asserts.sv ----
// port checker for the trip target logic
`timescale 1ns/1ns
`default_nettype none
module trip_targets_asserts
  import tgt_pkg::*;
(
  // clock, reset, inputs
  input wire logic                MCLK,
  input wire logic                NRST,
  input wire logic                TRIP,
  input wire logic [NUM_DIFF-1:0] DIFF_PICKUP,
  input wire logic [2:0]          DIFF_PHASE,
  input wire logic [NUM_IOC-1:0]  IOC_PICKUP,
  input wire logic [NUM_TOC-1:0]  TOC_TIMEOUT,
  input wire logic [NUM_RES-1:0]  RES_TRIP,
  input wire logic                CLEAR_BUTTON,
  input wire logic                CLEAR_SERIAL,
  input wire logic                TGT_REASSIGNED,
  input wire logic                SELFTEST_FAIL,
  // outputs
  input wire logic                NV_WRITE,
  input wire logic [NUM_TGT-1:0]  NV_WDATA,
  input wire logic [NUM_LEDS-1:0] LEDS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // trip edge and a settled clear request
  sequence s_rise; $rose(TRIP); endsequence
  sequence s_clr; ((CLEAR_BUTTON | CLEAR_SERIAL) & !TRIP)[*3]; endsequence
  a_diff_first: assert property (s_rise ##0 |DIFF_PICKUP |=> LEDS[1])
    else $error("diff target missed");
  a_ioc_second: assert property (s_rise ##1 |IOC_PICKUP |=> LEDS[2])
    else $error("inst target missed");
  a_toc_first: assert property (s_rise ##0 |TOC_TIMEOUT |=> LEDS[3])
    else $error("inverse target missed");
  a_res_second: assert property (s_rise ##1 |RES_TRIP |=> LEDS[7])
    else $error("residual target missed");
  a_diff_phase: assert property (s_rise ##0 DIFF_PHASE[1] |=> LEDS[5])
    else $error("phase b target missed");
  a_hold_trip: assert property ($past(TRIP) && $past(NRST) |->
    (LEDS[7:1] & $past(LEDS[7:1])) == $past(LEDS[7:1])) else $error("targets lost during trip");
  a_nv_store: assert property ($past(NRST, 2) && LEDS[7:1] != $past(LEDS[7:1]) |->
    NV_WRITE && NV_WDATA == LEDS[7:1]) else $error("target change not stored");
  a_clear_done: assert property (s_clr |=> LEDS[7:1] == '0)
    else $error("targets not cleared");
  a_en_lit: assert property ((!SELFTEST_FAIL && !TGT_REASSIGNED)[*3] |=> LEDS[0])
    else $error("in-service led dark");
  a_en_dark: assert property (SELFTEST_FAIL[*3] |=> !LEDS[0])
    else $error("in-service led lit");
endmodule // trip_targets_asserts
`default_nettype wire

// ---- verification/trip_targets_tb_top.sv ----
// self-checking bench for the trip target logic
`timescale 1ns/1ns
`default_nettype none
module trip_targets_tb_top
  import tgt_pkg::*;
;
  logic MCLK = 0, NRST = 0, TRIP = 0, CLEAR_BUTTON = 0, CLEAR_SERIAL = 0;
  logic TGT_REASSIGNED = 0, SELFTEST_FAIL = 0, NV_VALID, NV_WRITE;
  logic [NUM_DIFF-1:0] DIFF_PICKUP = '0;
  logic [2:0] DIFF_PHASE = '0;
  logic [NUM_IOC-1:0] IOC_PICKUP = '0;
  logic [NUM_TOC-1:0] TOC_TIMEOUT = '0;
  logic [NUM_RES-1:0] RES_TRIP = '0;
  logic [NUM_POC-1:0] POC_TRIP = '0;
  logic [NUM_SEQ-1:0] SEQ_TRIP = '0;
  logic [3*MAG_W-1:0] PHASE_MAG = '0;
  logic [NUM_POC*MAG_W-1:0] POC_PICKUP = '0;
  logic [NUM_TGT-1:0] NV_RDATA, NV_WDATA, exp_q;
  logic [NUM_LEDS-1:0] LEDS;
  logic [31:0] lfsr = 32'h000147b2;
  int errors = 0, comparisons = 0;
  always #4 MCLK = ~MCLK;
  trip_targets dut (.MCLK, .NRST, .TRIP, .DIFF_PICKUP, .DIFF_PHASE, .IOC_PICKUP, .TOC_TIMEOUT,
    .RES_TRIP, .POC_TRIP, .SEQ_TRIP, .PHASE_MAG, .POC_PICKUP, .CLEAR_BUTTON, .CLEAR_SERIAL,
    .TGT_REASSIGNED, .SELFTEST_FAIL, .NV_VALID, .NV_RDATA, .NV_WRITE, .NV_WDATA, .LEDS);
  nv_store_model nv (.clk(MCLK), .nv_write(NV_WRITE), .nv_wdata(NV_WDATA), .nv_valid(NV_VALID),
    .nv_rdata(NV_RDATA));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // drive one random fault sample, model its targets
  task automatic fault(output logic [NUM_TGT-1:0] t);
    logic [31:0] r;
    logic [63:0] m, k;
    int b;
    r = rnd() & rnd() & rnd();
    m = {rnd(), rnd()};
    k = {rnd(), rnd()};
    t = {|r[14:13], r[17:15], |r[12:8], |r[7:2], |r[1:0]};
    b = 0;
    for (int p = 0; p < 3; p++) begin
      for (int e = 0; e < NUM_POC; e++) if (r[18+e] && m[16*p+:16] > k[16*e+:16]) t[3+p] = 1;
      if (m[16*p+:16] > m[16*b+:16]) b = p;
    end
    if (|r[25:22] || |r[14:13]) t[3+b] = 1;
    {SEQ_TRIP, POC_TRIP, DIFF_PHASE, RES_TRIP, TOC_TIMEOUT, IOC_PICKUP, DIFF_PICKUP} <= r[25:0];
    PHASE_MAG <= m[47:0];
    POC_PICKUP <= k;
  endtask
  // trip edge with two samples and a third that must be ignored
  task automatic trip_pair();
    logic [NUM_TGT-1:0] t0, t1, tj;
    fault(t0);
    TRIP <= 1;
    tick(1);
    fault(t1);
    tick(1);
    fault(tj);
    tick(1);
    exp_q = exp_q | t0 | t1;
    #1 check("targets", LEDS[7:1], exp_q);
    check("nv copy", NV_RDATA, exp_q);
    check("in service", LEDS[0], 1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    tick(6);
    NRST <= 1;
    tick(2);
    exp_q = '0;
    for (int i = 0; i < 40; i++) begin
      trip_pair();
      tick(1);
      CLEAR_BUTTON <= (i % 3 == 0);
      CLEAR_SERIAL <= (i % 3 == 1);
      tick(4);
      #1 check("held", LEDS[7:1], exp_q);
      tick(1);
      TRIP <= 0;
      tick(4);
      if (i % 3 != 2) exp_q = '0;
      #1 check("cleared", LEDS[7:1], exp_q);
      tick(1);
      CLEAR_BUTTON <= 0;
      CLEAR_SERIAL <= 0;
      tick(3);
    end
    $display("capture and clear done");
    SELFTEST_FAIL <= 1;
    tick(4);
    #1 check("self test", LEDS[0], 0);
    tick(1);
    SELFTEST_FAIL <= 0;
    TGT_REASSIGNED <= 1;
    tick(4);
    #1 check("reassigned", LEDS[0], 0);
    tick(1);
    TGT_REASSIGNED <= 0;
    trip_pair();
    tick(1);
    TRIP <= 0;
    NRST <= 0;
    tick(3);
    #1 check("in reset", LEDS, 0);
    tick(1);
    NRST <= 1;
    tick(2);
    #1 check("restored", LEDS[7:1], exp_q);
    $display("led and restore done");
    complete_run();
  end
  // watchdog
  initial begin
    tick(20000);
    errors++;
    complete_run();
  end
endmodule // trip_targets_tb_top
bind trip_targets trip_targets_asserts chk (.MCLK, .NRST, .TRIP, .DIFF_PICKUP, .DIFF_PHASE, .IOC_PICKUP,
  .TOC_TIMEOUT, .RES_TRIP, .CLEAR_BUTTON, .CLEAR_SERIAL, .TGT_REASSIGNED, .SELFTEST_FAIL, .NV_WRITE,
  .NV_WDATA, .LEDS);
`default_nettype wire
